/* common/dmsfe_map.vh */
// constants of the dual mode serial front end
`ifndef DMSFE_MAP_VH
`define DMSFE_MAP_VH

// =====================================================================
// asynchronous character timing, in carrier clock periods
`define DMSFE_ETU_TICKS    9'd372
`define DMSFE_ETU_LAST     9'd371
`define DMSFE_ETU_HALF     9'd186
`define DMSFE_TICK_ZERO    9'd0
`define DMSFE_TICK_ONE     9'd1

// =====================================================================
// asynchronous character framing
`define DMSFE_TX_LAST_BIT  4'd11
`define DMSFE_RX_START_BIT 4'd0
`define DMSFE_RX_PAR_BIT   4'd9
`define DMSFE_ATR_LAST     3'd7
`define DMSFE_ATR_BITS     64

// =====================================================================
// synchronous bus framing
`define DMSFE_BYTE_DONE    4'd8
`define DMSFE_CNT_ZERO     4'd0
`define DMSFE_CNT_ONE      4'd1
`define DMSFE_ADDR_HI      4
`define DMSFE_ADDR_LO      1
`define DMSFE_RW_BIT       0

// =====================================================================
// state codes
`define DMSFE_S_IDLE       3'd0
`define DMSFE_S_ADDR       3'd1
`define DMSFE_S_ACK        3'd2
`define DMSFE_S_WR         3'd3
`define DMSFE_S_RD         3'd4
`define DMSFE_S_RACK       3'd5
`define DMSFE_A_IDLE       2'd0
`define DMSFE_A_TX         2'd1
`define DMSFE_A_RX         2'd2

// =====================================================================
// synchroniser reset levels: scl, sda, reset pad, mode strap
`define DMSFE_SYNC_RST     4'hE

`endif

/* src/dmsfe_sync.v */
// two flip-flop synchroniser for pin inputs
`timescale 1ns/10ps
module dmsfe_sync #(
  parameter W       = 4,          // number of bits
  parameter RST_VAL = {W{1'b0}}   // level held during reset
) (
  input  wire         clk,        // core clock
  input  wire         rst,        // synchronous reset, active high
  input  wire         ce,         // clock enable
  input  wire [W-1:0] d,          // asynchronous inputs
  output wire [W-1:0] q           // synchronised outputs
);

  reg [W-1:0] meta_q;             // first stage, read only by second
  reg [W-1:0] sync_q;             // second stage

  // ===================================================================
  // two stages
  always @(posedge clk) begin
    if (rst) begin
      meta_q <= RST_VAL;
      sync_q <= RST_VAL;
    end else if (ce) begin
      meta_q <= d;
      sync_q <= meta_q;
    end
  end

  assign q = sync_q;

endmodule // dmsfe_sync

/* src/dmsfe_top.v */
// dual mode serial front end: card character link and two-wire bus slave
//
// Overview of operation
// - async bit cell lasts 372 carrier periods
// - sync write bits sampled on rising clock
// - sync read bits changed on falling clock
// - async reset release sends 64-bit answer bytes
// - no answer sequence in sync mode
// - floating reset pin reads inactive, pulled up
// - one data pin, driven low or released
// - respond only to own four-bit address
// - data changes with clock high: start/stop
// - start is data falling while clock high
`timescale 1ns/10ps
`include "dmsfe_map.vh"
module dmsfe_top (
  input  wire        clk,         // core clock, 100 MHz
  input  wire        rst,         // synchronous reset, active high
  input  wire        ce,          // clock enable, freezes all state when low
  input  wire        pin_clk_i,   // card carrier clock or serial bus clock pin
  input  wire        pin_rst_n_i, // card reset pin, pulled up in the pad
  input  wire        pin_io_i,    // data pin level as seen on the wire
  output wire        pin_io_o,    // data pin output level, always low
  output wire        pin_io_oe_n, // data pin drive enable, low while pulling low
  input  wire        async_mode_i,// mode strap: 1 card character mode, 0 bus
  input  wire [3:0]  dev_addr_i,  // own bus address
  input  wire [63:0] atr_data_i,  // answer-to-reset bytes, byte 0 in bits 7:0
  input  wire [7:0]  tx_data_i,   // next byte to send
  input  wire        tx_valid_i,  // tx_data_i holds a byte (async mode)
  output wire        tx_take_o,   // pulse: tx_data_i has been taken
  output wire [7:0]  rx_byte_o,   // last received byte
  output wire        rx_valid_o,  // pulse: rx_byte_o is new
  output wire        rx_perr_o,   // parity error of last async byte
  output wire        selected_o,  // bus transfer addressed to this device
  output wire        atr_busy_o   // answer-to-reset in progress
);

  wire [3:0] pins_s;              // synchronised pins
  wire       scl_s;               // clock pin
  wire       sda_s;               // data pin
  wire       rstp_s;              // reset pin, high inactive
  wire       async_s;             // mode strap

  reg        scl_p_q;             // clock pin, one cycle back
  reg        sda_p_q;             // data pin, one cycle back
  reg        rstp_p_q;            // reset pin, one cycle back
  reg        io_o_q;              // output level flop
  reg        oe_n_q;              // pin drive enable
  reg  [7:0] rx_byte_q;           // received byte
  reg        rx_valid_q;          // received strobe
  reg        rx_perr_q;           // parity error
  reg        tx_take_q;           // byte taken strobe
  reg        sel_q;               // addressed
  reg        atr_busy_q;          // answer sequence running
  reg  [2:0] atr_idx_q;           // answer byte index
  reg  [2:0] s_state_q;           // bus state
  reg        rw_q;                // bus read flag
  reg  [3:0] cnt_q;               // bit counter, both modes
  reg  [7:0] sh_q;                // shift register, bus mode
  reg  [1:0] a_state_q;           // character state
  reg  [8:0] etu_q;               // carrier tick counter within a cell
  reg [11:0] txsh_q;              // outgoing character, lsb first
  reg  [8:0] rxsh_q;              // incoming data and parity

  // ===================================================================
  // pin synchronisers; the reset pad is pulled up so it idles high
  dmsfe_sync #(
    .W       (4),
    .RST_VAL (`DMSFE_SYNC_RST)
  ) u_sync (
    .clk (clk),
    .rst (rst),
    .ce  (ce),
    .d   ({pin_clk_i, pin_io_i, pin_rst_n_i, async_mode_i}),
    .q   (pins_s)
  );

  assign scl_s   = pins_s[3];
  assign sda_s   = pins_s[2];
  assign rstp_s  = pins_s[1];
  assign async_s = pins_s[0];

  // ===================================================================
  // edge and condition detection
  wire scl_rise = scl_s & ~scl_p_q;
  wire scl_fall = ~scl_s & scl_p_q;
  wire bus_start = scl_s & scl_p_q & sda_p_q & ~sda_s;
  wire bus_stop  = scl_s & scl_p_q & ~sda_p_q & sda_s;
  wire car_tick  = scl_rise;                             // carrier period
  wire io_fall   = sda_p_q & ~sda_s;
  wire rst_rise  = rstp_s & ~rstp_p_q;
  wire addr_hit  = (sh_q[`DMSFE_ADDR_HI:`DMSFE_ADDR_LO] == dev_addr_i);

  // even parity of a byte
  function par8;
    input [7:0] b;
    begin
      par8 = ^b;
    end
  endfunction

  // source of the next async character
  wire [7:0] atr_byte = atr_data_i[{atr_idx_q, 3'b000} +: 8];
  wire [7:0] a_byte   = atr_busy_q ? atr_byte : tx_data_i;

  // ===================================================================
  // both protocol engines; one process so every flop has one driver
  always @(posedge clk) begin
    if (rst) begin
      scl_p_q    <= 1'b1;     // matches the clock synchroniser reset level
      sda_p_q    <= 1'b1;
      rstp_p_q   <= 1'b1;
      io_o_q     <= 1'b0;
      oe_n_q     <= 1'b1;
      rx_byte_q  <= 8'h00;
      rx_valid_q <= 1'b0;
      rx_perr_q  <= 1'b0;
      tx_take_q  <= 1'b0;
      sel_q      <= 1'b0;
      atr_busy_q <= 1'b0;
      atr_idx_q  <= 3'h0;
      s_state_q  <= `DMSFE_S_IDLE;
      rw_q       <= 1'b0;
      cnt_q      <= `DMSFE_CNT_ZERO;
      sh_q       <= 8'h00;
      a_state_q  <= `DMSFE_A_IDLE;
      etu_q      <= `DMSFE_TICK_ZERO;
      txsh_q     <= 12'hFFF;
      rxsh_q     <= 9'h000;
    end else if (ce) begin
      scl_p_q    <= scl_s;
      sda_p_q    <= sda_s;
      rstp_p_q   <= rstp_s;
      io_o_q     <= 1'b0;
      rx_valid_q <= 1'b0;
      tx_take_q  <= 1'b0;
      if (!async_s) begin
        // bus mode: no answer sequence, reset pin ignored
        atr_busy_q <= 1'b0;
        a_state_q  <= `DMSFE_A_IDLE;
        if (bus_start) begin
          s_state_q <= `DMSFE_S_ADDR;
          cnt_q     <= `DMSFE_CNT_ZERO;
          oe_n_q    <= 1'b1;
          sel_q     <= 1'b0;
        end else if (bus_stop) begin
          s_state_q <= `DMSFE_S_IDLE;
          oe_n_q    <= 1'b1;
          sel_q     <= 1'b0;
        end else begin
          case (s_state_q)
            `DMSFE_S_ADDR, `DMSFE_S_WR: begin
              if (scl_rise && cnt_q != `DMSFE_BYTE_DONE) begin
                sh_q  <= {sh_q[6:0], sda_s};
                cnt_q <= cnt_q + `DMSFE_CNT_ONE;
              end else if (scl_fall && cnt_q == `DMSFE_BYTE_DONE) begin
                if (s_state_q == `DMSFE_S_WR) begin
                  rx_byte_q  <= sh_q;
                  rx_valid_q <= 1'b1;
                  oe_n_q     <= 1'b0;       // acknowledge
                  s_state_q  <= `DMSFE_S_ACK;
                end else if (addr_hit) begin
                  rw_q      <= sh_q[`DMSFE_RW_BIT];
                  sel_q     <= 1'b1;
                  oe_n_q    <= 1'b0;
                  s_state_q <= `DMSFE_S_ACK;
                end else begin
                  s_state_q <= `DMSFE_S_IDLE;
                end
              end
            end
            `DMSFE_S_ACK: begin
              if (scl_fall) begin
                if (rw_q) begin
                  oe_n_q    <= tx_data_i[7];
                  sh_q      <= {tx_data_i[6:0], 1'b1};
                  tx_take_q <= 1'b1;
                  cnt_q     <= `DMSFE_CNT_ONE;
                  s_state_q <= `DMSFE_S_RD;
                end else begin
                  oe_n_q    <= 1'b1;
                  cnt_q     <= `DMSFE_CNT_ZERO;
                  s_state_q <= `DMSFE_S_WR;
                end
              end
            end
            `DMSFE_S_RD: begin
              if (scl_fall) begin
                if (cnt_q == `DMSFE_BYTE_DONE) begin
                  oe_n_q    <= 1'b1;        // free line for host acknowledge
                  s_state_q <= `DMSFE_S_RACK;
                end else begin
                  oe_n_q <= sh_q[7];
                  sh_q   <= {sh_q[6:0], 1'b1};
                  cnt_q  <= cnt_q + `DMSFE_CNT_ONE;
                end
              end
            end
            `DMSFE_S_RACK: begin
              if (scl_rise) begin
                s_state_q <= sda_s ? `DMSFE_S_IDLE : `DMSFE_S_ACK;
                sel_q     <= ~sda_s;
              end
            end
            default: begin
              oe_n_q    <= 1'b1;
              s_state_q <= `DMSFE_S_IDLE;
            end
          endcase
        end
      end else if (!rstp_s) begin
        // card held in reset: idle, line released
        s_state_q  <= `DMSFE_S_IDLE;
        sel_q      <= 1'b0;
        a_state_q  <= `DMSFE_A_IDLE;
        atr_busy_q <= 1'b0;
        oe_n_q     <= 1'b1;
      end else begin
        s_state_q <= `DMSFE_S_IDLE;
        sel_q     <= 1'b0;
        if (rst_rise) begin
          atr_busy_q <= 1'b1;
          atr_idx_q  <= 3'h0;
        end
        case (a_state_q)
          `DMSFE_A_IDLE: begin
            oe_n_q <= 1'b1;
            if (atr_busy_q || tx_valid_i) begin
              txsh_q    <= {2'b11, par8(a_byte), a_byte, 1'b0};
              tx_take_q <= ~atr_busy_q;
              etu_q     <= `DMSFE_TICK_ZERO;
              cnt_q     <= `DMSFE_CNT_ZERO;
              a_state_q <= `DMSFE_A_TX;
            end else if (io_fall) begin
              etu_q     <= `DMSFE_ETU_HALF;
              cnt_q     <= `DMSFE_RX_START_BIT;
              a_state_q <= `DMSFE_A_RX;
            end
          end
          `DMSFE_A_TX: begin
            oe_n_q <= txsh_q[0];
            if (car_tick) begin
              if (etu_q == `DMSFE_ETU_LAST) begin
                etu_q  <= `DMSFE_TICK_ZERO;
                txsh_q <= {1'b1, txsh_q[11:1]};
                cnt_q  <= cnt_q + `DMSFE_CNT_ONE;
                if (cnt_q == `DMSFE_TX_LAST_BIT) begin
                  a_state_q <= `DMSFE_A_IDLE;
                  if (atr_busy_q) begin
                    atr_idx_q  <= atr_idx_q + 3'h1;
                    atr_busy_q <= (atr_idx_q != `DMSFE_ATR_LAST);
                  end
                end
              end else begin
                etu_q <= etu_q + `DMSFE_TICK_ONE;
              end
            end
          end
          `DMSFE_A_RX: begin
            oe_n_q <= 1'b1;
            if (car_tick) begin
              if (etu_q == `DMSFE_ETU_LAST) begin
                etu_q  <= `DMSFE_TICK_ZERO;
                cnt_q  <= cnt_q + `DMSFE_CNT_ONE;
                rxsh_q <= {sda_s, rxsh_q[8:1]};
                if (cnt_q == `DMSFE_RX_START_BIT && sda_s) begin
                  a_state_q <= `DMSFE_A_IDLE;  // glitch, not a start bit
                end else if (cnt_q == `DMSFE_RX_PAR_BIT) begin
                  rx_byte_q  <= rxsh_q[8:1];
                  rx_perr_q  <= par8(rxsh_q[8:1]) ^ sda_s;
                  rx_valid_q <= 1'b1;
                  a_state_q  <= `DMSFE_A_IDLE;
                end
              end else begin
                etu_q <= etu_q + `DMSFE_TICK_ONE;
              end
            end
          end
          default: begin
            a_state_q <= `DMSFE_A_IDLE;
          end
        endcase
      end
    end
  end

  // ===================================================================
  // outputs straight from flops
  assign pin_io_o    = io_o_q;
  assign pin_io_oe_n = oe_n_q;
  assign tx_take_o   = tx_take_q;
  assign rx_byte_o   = rx_byte_q;
  assign rx_valid_o  = rx_valid_q;
  assign rx_perr_o   = rx_perr_q;
  assign selected_o  = sel_q;
  assign atr_busy_o  = atr_busy_q;

endmodule // dmsfe_top

/* tb/dmsfe_top_properties.sv */
// pin level checks of the dual mode serial front end
`timescale 1ns/10ps
module dmsfe_top_properties (
  input wire clk,          // core clock
  input wire rst,          // synchronous reset
  input wire pin_clk_i,    // carrier or serial clock
  input wire pin_rst_n_i,  // card reset pin
  input wire pin_io_i,     // data wire level
  input wire pin_io_o,     // data output level
  input wire pin_io_oe_n,  // data drive enable, low drives
  input wire async_mode_i, // mode strap
  input wire tx_take_o,    // byte taken
  input wire rx_valid_o,   // byte received
  input wire selected_o,   // addressed
  input wire atr_busy_o    // answer running
);
  reg        car_q;  // carrier level one cycle ago
  reg        oe_q;   // drive enable one cycle ago
  reg        seen_q; // a line change already seen in this answer
  reg [15:0] cnt_q;  // carrier rises since the last line change
  wire       rise = pin_clk_i & ~car_q;
  wire       flip = oe_q ^ pin_io_oe_n;
  // =====================================================================
  // carrier rises counted between line changes
  always @(posedge clk) begin
    car_q <= pin_clk_i;
    oe_q <= rst | pin_io_oe_n;
    seen_q <= ~rst & atr_busy_o & (seen_q | flip);
    cnt_q <= (rst | flip) ? {15'h0000, rise} : cnt_q + {15'h0000, rise};
  end
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);
  // =====================================================================
  // start and stop conditions on the two-wire bus
  sequence s_start;
    !async_mode_i && pin_clk_i && $fell(pin_io_i);
  endsequence
  sequence s_stop;
    !async_mode_i && pin_clk_i && $rose(pin_io_i);
  endsequence
  a_cell_length: assert property (
    flip && seen_q && async_mode_i && pin_rst_n_i && $past(pin_rst_n_i, 6)
    |-> cnt_q % 16'h0174 == 16'h0000) else $error("cell not a multiple of 372 carrier edges");
  a_drive_low_only: assert property (pin_io_o == 1'b0)
    else $error("data pin driven high");
  a_change_clock_low: assert property (
    !async_mode_i && $changed(pin_io_oe_n) |-> !pin_clk_i) else $error("data changed with clock high");
  a_read_load: assert property (
    tx_take_o && !async_mode_i |-> !pin_clk_i && $past(pin_clk_i, 6)) else $error("read byte taken off edge");
  a_write_byte_ack: assert property (
    rx_valid_o && !async_mode_i |-> !pin_clk_i ##[0:2] !pin_io_oe_n) else $error("written byte not acknowledged");
  a_select_ack: assert property ($rose(selected_o) |-> ##[0:2] !pin_io_oe_n)
    else $error("selected without acknowledge");
  a_start_deselect: assert property (s_start |-> ##[1:6] !selected_o)
    else $error("start did not end the transfer");
  a_stop_deselect: assert property (s_stop |-> ##[1:6] !selected_o [*4])
    else $error("stop did not end the transfer");
  a_sync_no_answer: assert property (
    !async_mode_i && !$past(async_mode_i, 4) |-> !atr_busy_o) else $error("answer in bus mode");
  a_answer_start: assert property (
    async_mode_i && $rose(pin_rst_n_i) |-> ##[2:8] atr_busy_o) else $error("answer did not start");
  a_answer_abort: assert property (
    (async_mode_i && !pin_rst_n_i) [*6] |-> !atr_busy_o && pin_io_oe_n) else $error("reset pin ignored");
endmodule // dmsfe_top_properties

bind dmsfe_top dmsfe_top_properties u_props (.clk(clk), .rst(rst), .pin_clk_i(pin_clk_i),
  .pin_rst_n_i(pin_rst_n_i), .pin_io_i(pin_io_i), .pin_io_o(pin_io_o), .pin_io_oe_n(pin_io_oe_n),
  .async_mode_i(async_mode_i), .tx_take_o(tx_take_o), .rx_valid_o(rx_valid_o),
  .selected_o(selected_o), .atr_busy_o(atr_busy_o));

/* tb/dmsfe_reader.sv */
// card reader and bus host model on the clock, reset and data pins
`timescale 1ns/10ps
module dmsfe_reader (
  input  wire clk,      // core clock
  input  wire line,     // resolved data wire
  output reg  scl_q,    // carrier or serial clock pin, still between frames
  output reg  pull_q,   // host pulls the data wire low
  output reg  rst_n_q   // card reset pin
);
  localparam H = 20;    // bus half period in core cycles
  initial begin
    scl_q = 1'b1;
    pull_q = 1'b0;
    rst_n_q = 1'b1;
  end
  // =====================================================================
  // pin tasks
  task pin_rst(input v);
    rst_n_q <= v;
  endtask
  // one 80 ns carrier period ending on its rising edge
  task rise;
    begin
      repeat (4) @(posedge clk);
      scl_q <= 1'b0;
      repeat (4) @(posedge clk);
      scl_q <= 1'b1;
    end
  endtask
  // receive one character: sample mid-cell, start then eight bits then parity
  task async_rx(output [8:0] r, output tmo);
    reg [9:0] b;
    integer   i;
    integer   k;
    begin
      k = 0;
      while (line === 1'b1 && k < 2000) begin
        rise;
        k = k + 1;
      end
      tmo = (k == 2000);
      for (i = 0; i < 10; i = i + 1) begin
        repeat (i == 0 ? 186 : 372) rise;
        b[i] = line;
      end
      r = {b[0] | ^b[9:1], b[8:1]}; // flag: start not low or odd parity
    end
  endtask
  // send one character: start, eight bits lsb first, parity, one guard cell released
  task async_tx(input [8:0] v);
    integer i;
    begin
      for (i = 0; i < 11; i = i + 1) begin
        pull_q <= (i == 0) ? 1'b1 : (i == 10) ? 1'b0 : ~v[i - 1];
        repeat (372) rise;
      end
    end
  endtask
  task bus_start;
    begin
      pull_q <= 1'b1;
      repeat (H) @(posedge clk);
      scl_q <= 1'b0;
    end
  endtask
  task bus_stop;
    begin
      repeat (H / 2) @(posedge clk);
      pull_q <= 1'b1;
      repeat (H / 2) @(posedge clk);
      scl_q <= 1'b1;
      repeat (H) @(posedge clk);
      pull_q <= 1'b0;
      repeat (H) @(posedge clk);
    end
  endtask
  // nine clocks, msb first; data set with clock low, wire read before the fall
  task bus_xfer(input [8:0] d, output [8:0] r);
    integer i;
    for (i = 8; i >= 0; i = i - 1) begin
      repeat (H / 2) @(posedge clk);
      pull_q <= ~d[i];
      repeat (H / 2) @(posedge clk);
      scl_q <= 1'b1;
      repeat (H) @(posedge clk);
      r[i] = line;
      scl_q <= 1'b0;
    end
  endtask
endmodule // dmsfe_reader

/* tb/dmsfe_top_bench.sv */
// self-checking bench of the dual mode serial front end
`timescale 1ns/10ps
module dmsfe_top_bench;
  reg         clk = 1'b0;     // core clock
  reg         rst = 1'b1;     // synchronous reset
  reg         mode = 1'b0;    // mode strap
  reg  [3:0]  addr = 4'h0;    // own address
  reg  [63:0] atr = 64'h0;    // answer bytes
  reg  [7:0]  txd = 8'h00;    // byte read back by the host
  reg  [8:0]  got_q = 9'h000; // result seen by the far side
  reg         got_v = 1'b0;   // got_q is new
  reg  [8:0]  q [$];          // expected results, oldest first
  reg  [8:0]  r;              // far side result
  reg  [8:0]  e;              // scratch
  reg  [7:0]  d;              // written byte
  reg         tmo;            // start bit never came
  integer     seed = 32'h7B23C861;
  integer     n_errors = 0;
  integer     samples_checked = 0;
  integer     i;
  integer     rnd;            // raw random word
  reg         ce = 1'b1;      // clock enable
  reg         txv = 1'b0;     // card transmit byte offered
  reg  [8:0]  n_take = 9'h000; // bytes taken by the design
  wire        scl, pull, rst_n, oe_n, rxv, sel, busy, io_o, taken, perr;
  wire [7:0]  rxb;
  wire        line = ~(pull | ~oe_n); // pulled up unless someone drives low
  dmsfe_reader host (.clk(clk), .line(line), .scl_q(scl), .pull_q(pull), .rst_n_q(rst_n));
  dmsfe_top dut (.clk(clk), .rst(rst), .ce(ce), .pin_clk_i(scl), .pin_rst_n_i(rst_n),
    .pin_io_i(line), .pin_io_o(io_o), .pin_io_oe_n(oe_n), .async_mode_i(mode),
    .dev_addr_i(addr), .atr_data_i(atr), .tx_data_i(txd), .tx_valid_i(txv),
    .tx_take_o(taken), .rx_byte_o(rxb), .rx_valid_o(rxv), .rx_perr_o(perr),
    .selected_o(sel), .atr_busy_o(busy));
  always #5 clk = ~clk;
  // =====================================================================
  // comparison and reporting
  task chk(input [8:0] a, input [8:0] b);
    begin
      samples_checked = samples_checked + 1;
      if (a !== b) begin
        n_errors = n_errors + 1;
        $display("wrong value at %0t: got %h expected %h", $time, a, b);
      end
    end
  endtask
  task take(input [8:0] v);
    begin
      e = (q.size() > 0) ? q.pop_front() : ~v;
      chk(v, e);
    end
  endtask
  task final_report;
    begin
      chk({8'h00, q.size() == 0}, 9'h001);
      $display("comparisons %0d, mismatches %0d", samples_checked, n_errors);
      if (n_errors == 0 && samples_checked > 0) begin
        $display("ALL TESTS PASSED");
      end else begin
        $display("TESTS FAILED");
      end
      $finish;
    end
  endtask
  // note the expectation, run one bus byte, hand the result to the watcher
  task xf(input [8:0] dv, input [8:0] x);
    begin
      q.push_back(x);
      host.bus_xfer(dv, r);
      got_q <= r;
      got_v <= 1'b1;
      @(posedge clk);
      got_v <= 1'b0;
    end
  endtask
  // watcher: every result takes the oldest note
  always @(posedge clk) begin
    if (rxv === 1'b1) take({1'b0, rxb});
    if (got_v === 1'b1) take(got_q);
    if (taken === 1'b1) n_take <= n_take + 9'h001;
  end
  // =====================================================================
  // main sequence
  initial begin
    @(posedge clk);
    rnd = $random(seed);
    addr <= rnd[3:0];
    atr <= {$random(seed), $random(seed)};
    rnd = $random(seed);
    txd <= rnd[7:0];
    @(posedge clk);
    rst <= 1'b0;
    repeat (3) @(posedge clk);
    for (i = 0; i < 2; i = i + 1) begin
      rnd = $random(seed);
      e = rnd[8:0];
      e[5:2] = addr ^ (4'h1 << i);
      e[0] = 1'b1;
      host.bus_start;
      xf(e, e);
      xf(9'h1FF, 9'h1FF);
      host.bus_stop;
    end
    $display("test foreign address done");
    rnd = $random(seed);
    d = rnd[7:0];
    host.bus_start;
    xf({3'h0, addr, 2'h1}, {3'h0, addr, 2'h0});
    q.push_back({1'b0, d});
    xf({d, 1'b1}, {d, 1'b0});
    chk({8'h00, sel}, 9'h001);
    host.bus_stop;
    repeat (8) @(posedge clk);
    chk({8'h00, sel}, 9'h000);
    host.bus_start;
    xf({3'h0, addr, 2'h3}, {3'h0, addr, 2'h2});
    xf(9'h1FF, {txd, 1'b1});
    host.bus_stop;
    chk(n_take, 9'h001);
    $display("test bus write and read done");
    host.pin_rst(1'b0);
    repeat (40) @(posedge clk);
    host.pin_rst(1'b1);
    repeat (40) @(posedge clk);
    chk({7'h00, busy, oe_n}, 9'h001);
    chk({8'h00, io_o}, 9'h000);
    // strap to card mode with the reset pin already high: idle, no answer
    mode <= 1'b1;
    repeat (8) @(posedge clk);
    rnd = $random(seed);
    d = rnd[7:0];
    q.push_back({1'b0, d});
    // parity sent inverted, so the error flag must rise
    host.async_tx({~^d, d});
    chk({8'h00, perr}, 9'h001);
    $display("test card receive done");
    host.pin_rst(1'b0);
    repeat (20) @(posedge clk);
    q.push_back({1'b0, atr[7:0]});
    host.pin_rst(1'b1);
    host.async_rx(r, tmo);
    if (tmo === 1'b1) begin
      n_errors = n_errors + 1;
      $display("wrong value at %0t: no start bit", $time);
    end else begin
      got_q <= r;
      got_v <= 1'b1;
      @(posedge clk);
      got_v <= 1'b0;
      for (i = 0; i < 1000; i = i + 1) host.rise;
      chk({8'h00, line}, 9'h000);
      host.pin_rst(1'b0);
      repeat (20) @(posedge clk);
      chk({7'h00, busy, oe_n}, 9'h001);
      $display("test answer sequence done");
    end
    final_report;
  end
endmodule // dmsfe_top_bench
